// >>> pkg/rxagc_defs.svh
`ifndef RXAGC_DEFS_SVH
`define RXAGC_DEFS_SVH

// ****************************************************************
// Register byte offsets (haddr[7:0])
// ****************************************************************
`define RXAGC_OFF_CTRL_ONE 8'h00
`define RXAGC_OFF_CTRL_TWO 8'h04
`define RXAGC_OFF_CTRL_THREE 8'h08
`define RXAGC_OFF_CTRL_FOUR 8'h0C
`define RXAGC_OFF_LOCK 8'h10
`define RXAGC_OFF_STATUS 8'h14
`define RXAGC_OFF_RSSI 8'h18

// ****************************************************************
// Reset values
// ****************************************************************
`define RXAGC_RST_CTRL_ONE 8'h00
`define RXAGC_RST_CTRL_TWO 8'h55
`define RXAGC_RST_CTRL_THREE 8'h2A
`define RXAGC_RST_CTRL_FOUR 8'h48
`define RXAGC_RST_LOCK 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define RXAGC_ONE_FREEZE_LSB 0
`define RXAGC_ONE_WAIT_LSB 2
`define RXAGC_ONE_BLANK_BIT 7
`define RXAGC_TWO_AVG_LSB 0
`define RXAGC_TWO_HYST_BIT 3
`define RXAGC_TWO_AMPLVL_BIT 4
`define RXAGC_TWO_AMPMAX_BIT 5
`define RXAGC_TWO_LOOPOFF_BIT 7
`define RXAGC_THREE_MAXGAIN_LSB 0
`define RXAGC_THREE_DOWN_LSB 5
`define RXAGC_FOUR_LEVEL_LSB 0
`define RXAGC_FOUR_UP_LSB 5
`define RXAGC_LOCK_SEL_LSB 0
`define RXAGC_LOCK_CSSET_BIT 4
`define RXAGC_STAT_CS_BIT 3

// ****************************************************************
// Timing counts and constants
// ****************************************************************
`define RXAGC_FREEZE_BASE 8'h10
`define RXAGC_WAIT_BASE 8'h10
`define RXAGC_WAIT_STEP 8'h04
`define RXAGC_WAIT_MAX 8'h30
`define RXAGC_AVG_BASE 8'h02
`define RXAGC_CS_OFFSET 9'h008
`define RXAGC_HYST 9'h002
`define RXAGC_LOCK_SEL_CS 4'h4

`endif

// >>> pkg/rxagc_pkg.sv
`default_nettype none

package rxagc_pkg;

    // ****************************************************************
    // Loop states
    // ****************************************************************
    typedef enum logic [1:0] {
        RXAGC_IDLE,
        RXAGC_FREEZE,
        RXAGC_WAIT,
        RXAGC_AVG
    } rxagc_state_t;

    // Software-visible control registers
    typedef struct packed {
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        logic [7:0] ctrl_three;
        logic [7:0] ctrl_four;
        logic [7:0] lock;
    } rxagc_regs_t;

    // Latched AHB address phase
    typedef struct packed {
        logic sel;
        logic write;
        logic [7:0] addr;
    } rxagc_ahb_t;

    // Whole state of the loop
    typedef struct packed {
        rxagc_state_t state;
        rxagc_regs_t regs;
        rxagc_ahb_t ahb;
        logic [31:0] hrdata;
        logic [7:0] cnt;
        logic [11:0] acc;
        logic [7:0] avg;
        logic avg_valid;
        logic [4:0] gain;
        logic cs;
        logic lock_out;
        logic pend_up;
        logic pend_dn;
        logic [4:0] prev;
    } rxagc_core_t;

endpackage : rxagc_pkg

`default_nettype wire

// >>> hdl/rxagc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Two-stage synchroniser for asynchronous level inputs
// ****************************************************************
module rxagc_sync #(
    parameter int W = 5
) (
    input wire logic clk_sys, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic [W-1:0] async_in, // Levels from outside the domain
    output logic [W-1:0] sync_out // Levels safe to use
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } rxagc_sync_state_t;

    rxagc_sync_state_t sync_reg;
    rxagc_sync_state_t sync_next;

    // First stage feeds only the second
    always_comb
    begin
        sync_next = sync_reg;
        sync_next.meta = async_in;
        sync_next.stable = sync_reg.meta;
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            sync_reg <= '0;
        end
        else
        begin
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg.stable;

endmodule : rxagc_sync

`default_nettype wire

// >>> hdl/rxagc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rxagc_defs.svh"

module rxagc_top (
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic reset, // Synchronous reset, active high
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response, always OKAY
    output logic [31:0] hrdata, // AHB read data
    input wire logic adc_clk_in, // ADC clock level from front end
    input wire logic filter_clk_in, // Filter clock level, twice bandwidth
    input wire logic rx_enable, // Receiver powered up
    input wire logic pll_lock, // PLL lock indication
    input wire logic freq_set_b, // Frequency register set B selected
    input wire logic [7:0] mag_sample, // Magnitude sample from IF path
    output logic [4:0] vga_gain, // Gain code to the analog amplifier
    output logic second_front_amp_max, // Force maximum second amplifier gain
    output logic second_front_amp_level, // Second amplifier change level
    output logic carrier_sense, // Carrier sense indicator
    output logic lock_pin, // Selectable lock output pin
    output logic [7:0] rssi_value // Latest averaged RSSI
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Post-step wait length in filter ticks
    function automatic logic [7:0] wait_len(input logic [2:0] sel, input logic blank);
        logic [7:0] len;
        len = (sel == 3'd7) ? `RXAGC_WAIT_MAX : 8'(`RXAGC_WAIT_BASE + `RXAGC_WAIT_STEP * sel);
        if (blank)
        begin
            len = {1'b0, len[7:1]};
        end
        return len;
    endfunction : wait_len

    // Number of samples in one average
    function automatic logic [7:0] avg_len(input logic [1:0] sel);
        return 8'(`RXAGC_AVG_BASE << sel);
    endfunction : avg_len

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [4:0] pins_sync;

    rxagc_sync #(
        .W(5)
    ) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in({freq_set_b, pll_lock, rx_enable, filter_clk_in, adc_clk_in}),
        .sync_out(pins_sync)
    );

    // ****************************************************************
    // State
    // ****************************************************************
    rxagc_pkg::rxagc_core_t core_reg;
    rxagc_pkg::rxagc_core_t core_next;

    logic adc_tick;
    logic filt_tick;
    logic restart;
    logic [4:0] max_gain;
    logic [8:0] lim_lo;
    logic [8:0] lim_hi;
    logic [8:0] cs_lim;
    logic [11:0] acc_sum;
    logic [7:0] avg_new;
    logic loop_off;
    logic hyst_on;
    logic too_hi;
    logic too_lo;

    // Edges of the synchronised levels
    assign adc_tick = pins_sync[0] & ~core_reg.prev[0];
    assign filt_tick = pins_sync[1] & ~core_reg.prev[1];
    assign restart = (pins_sync[2] & ~core_reg.prev[2])
        | (pins_sync[2] & pins_sync[3] & ~core_reg.prev[3])
        | (pins_sync[2] & (pins_sync[4] ^ core_reg.prev[4]));

    // Field decode
    assign max_gain = core_reg.regs.ctrl_three[`RXAGC_THREE_MAXGAIN_LSB +: 5];
    assign loop_off = core_reg.regs.ctrl_two[`RXAGC_TWO_LOOPOFF_BIT];
    assign hyst_on = core_reg.regs.ctrl_two[`RXAGC_TWO_HYST_BIT];

    // Limits around the carrier level
    always_comb
    begin
        lim_lo = {4'h0, core_reg.regs.ctrl_four[`RXAGC_FOUR_LEVEL_LSB +: 5]}
            + {6'h00, core_reg.regs.ctrl_four[`RXAGC_FOUR_UP_LSB +: 3]};
        lim_hi = lim_lo + {6'h00, core_reg.regs.ctrl_three[`RXAGC_THREE_DOWN_LSB +: 3]};
        if (hyst_on)
        begin
            lim_hi = lim_hi + `RXAGC_HYST;
            lim_lo = (lim_lo > `RXAGC_HYST) ? (lim_lo - `RXAGC_HYST) : 9'h000;
        end
        cs_lim = {4'h0, core_reg.regs.ctrl_four[`RXAGC_FOUR_LEVEL_LSB +: 5]}
            + `RXAGC_CS_OFFSET;
    end

    // Average at the end of the window
    assign acc_sum = core_reg.acc + {4'h0, mag_sample};
    assign avg_new = 8'(acc_sum
        >> ({1'b0, core_reg.regs.ctrl_two[`RXAGC_TWO_AVG_LSB +: 2]} + 3'd1));
    assign too_hi = {1'b0, avg_new} > lim_hi;
    assign too_lo = {1'b0, avg_new} < lim_lo;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb
    begin
        core_next = core_reg;
        core_next.prev = pins_sync;

        // Bus: register write in data phase
        if (core_reg.ahb.sel && core_reg.ahb.write)
        begin
            unique case (core_reg.ahb.addr)
                `RXAGC_OFF_CTRL_ONE: core_next.regs.ctrl_one = hwdata[7:0];
                `RXAGC_OFF_CTRL_TWO: core_next.regs.ctrl_two = hwdata[7:0];
                `RXAGC_OFF_CTRL_THREE: core_next.regs.ctrl_three = hwdata[7:0];
                `RXAGC_OFF_CTRL_FOUR: core_next.regs.ctrl_four = hwdata[7:0];
                `RXAGC_OFF_LOCK: core_next.regs.lock = hwdata[7:0];
                default: core_next.regs = core_reg.regs;
            endcase
        end

        // Bus: latch address phase and prepare read data
        core_next.ahb.sel = hsel & htrans[1] & hready;
        core_next.ahb.write = hwrite;
        core_next.ahb.addr = haddr[7:0];
        if (hsel && htrans[1] && hready && !hwrite)
        begin
            unique case (haddr[7:0])
                `RXAGC_OFF_CTRL_ONE: core_next.hrdata = {24'h00_0000, core_reg.regs.ctrl_one};
                `RXAGC_OFF_CTRL_TWO: core_next.hrdata = {24'h00_0000, core_reg.regs.ctrl_two};
                `RXAGC_OFF_CTRL_THREE: core_next.hrdata = {24'h00_0000, core_reg.regs.ctrl_three};
                `RXAGC_OFF_CTRL_FOUR: core_next.hrdata = {24'h00_0000, core_reg.regs.ctrl_four};
                `RXAGC_OFF_LOCK: core_next.hrdata = {24'h00_0000, core_reg.regs.lock};
                `RXAGC_OFF_STATUS:
                begin
                    core_next.hrdata = 32'h0000_0000;
                    core_next.hrdata[`RXAGC_STAT_CS_BIT] = core_reg.cs;
                    core_next.hrdata[0] = core_reg.avg_valid;
                    core_next.hrdata[1] = (core_reg.state == rxagc_pkg::RXAGC_FREEZE)
                        || (core_reg.state == rxagc_pkg::RXAGC_WAIT);
                    core_next.hrdata[2] = ~loop_off;
                    core_next.hrdata[12:8] = core_reg.gain;
                end
                `RXAGC_OFF_RSSI: core_next.hrdata = {24'h00_0000, core_reg.avg};
                default: core_next.hrdata = 32'h0000_0000;
            endcase
        end

        // Loop sequencing
        if (!pins_sync[2])
        begin
            core_next.state = rxagc_pkg::RXAGC_IDLE;
            core_next.cs = 1'b0;
            core_next.avg_valid = 1'b0;
        end
        else if (restart)
        begin
            core_next.state = rxagc_pkg::RXAGC_FREEZE;
            core_next.gain = max_gain;
            core_next.cnt = 8'h00;
            core_next.acc = 12'h000;
            core_next.avg_valid = 1'b0;
            core_next.cs = 1'b0;
            core_next.pend_up = 1'b0;
            core_next.pend_dn = 1'b0;
        end
        else
        begin
            unique case (core_reg.state)
                rxagc_pkg::RXAGC_IDLE:
                begin
                    core_next.state = rxagc_pkg::RXAGC_FREEZE;
                    core_next.gain = max_gain;
                    core_next.cnt = 8'h00;
                end
                rxagc_pkg::RXAGC_FREEZE:
                begin
                    // Hold on ADC ticks: 16, 32, 64 or 128
                    if (adc_tick)
                    begin
                        if (core_reg.cnt + 8'h01 >= 8'(`RXAGC_FREEZE_BASE
                            << core_reg.regs.ctrl_one[`RXAGC_ONE_FREEZE_LSB +: 2]))
                        begin
                            core_next.state = rxagc_pkg::RXAGC_WAIT;
                            core_next.cnt = 8'h00;
                        end
                        else
                        begin
                            core_next.cnt = core_reg.cnt + 8'h01;
                        end
                    end
                end
                rxagc_pkg::RXAGC_WAIT:
                begin
                    // Settling after a step or after the freeze
                    if (filt_tick)
                    begin
                        if (core_reg.cnt + 8'h01 >= wait_len(
                            core_reg.regs.ctrl_one[`RXAGC_ONE_WAIT_LSB +: 3],
                            core_reg.regs.ctrl_one[`RXAGC_ONE_BLANK_BIT]))
                        begin
                            core_next.state = rxagc_pkg::RXAGC_AVG;
                            core_next.cnt = 8'h00;
                            core_next.acc = 12'h000;
                        end
                        else
                        begin
                            core_next.cnt = core_reg.cnt + 8'h01;
                        end
                    end
                end
                rxagc_pkg::RXAGC_AVG:
                begin
                    // Accumulate one sample per filter tick
                    if (filt_tick)
                    begin
                        core_next.acc = acc_sum;
                        core_next.cnt = core_reg.cnt + 8'h01;
                        if (core_reg.cnt + 8'h01 >= avg_len(
                            core_reg.regs.ctrl_two[`RXAGC_TWO_AVG_LSB +: 2]))
                        begin
                            core_next.avg = avg_new;
                            core_next.avg_valid = 1'b1;
                            core_next.cnt = 8'h00;
                            core_next.acc = 12'h000;
                            core_next.cs = ({1'b0, avg_new} > cs_lim)
                                && !core_reg.regs.lock[`RXAGC_LOCK_CSSET_BIT];
                            core_next.pend_up = 1'b0;
                            core_next.pend_dn = 1'b0;
                            if (!loop_off && too_hi && core_reg.gain != 5'h00)
                            begin
                                if (hyst_on && !core_reg.pend_dn)
                                begin
                                    core_next.pend_dn = 1'b1;
                                end
                                else
                                begin
                                    core_next.gain = core_reg.gain - 5'h01;
                                    core_next.state = rxagc_pkg::RXAGC_WAIT;
                                end
                            end
                            else if (!loop_off && too_lo && core_reg.gain < max_gain)
                            begin
                                if (hyst_on && !core_reg.pend_up)
                                begin
                                    core_next.pend_up = 1'b1;
                                end
                                else
                                begin
                                    core_next.gain = core_reg.gain + 5'h01;
                                    core_next.state = rxagc_pkg::RXAGC_WAIT;
                                end
                            end
                        end
                    end
                end
            endcase
        end

        // Gain ceiling and disabled loop
        if (loop_off || core_next.gain > max_gain)
        begin
            core_next.gain = max_gain;
        end

        // Lock pin selection
        core_next.lock_out = (core_reg.regs.lock[`RXAGC_LOCK_SEL_LSB +: 4] == `RXAGC_LOCK_SEL_CS)
            ? core_reg.cs : 1'b0;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            core_reg <= '0;
            core_reg.state <= rxagc_pkg::RXAGC_IDLE;
            core_reg.regs.ctrl_one <= `RXAGC_RST_CTRL_ONE;
            core_reg.regs.ctrl_two <= `RXAGC_RST_CTRL_TWO;
            core_reg.regs.ctrl_three <= `RXAGC_RST_CTRL_THREE;
            core_reg.regs.ctrl_four <= `RXAGC_RST_CTRL_FOUR;
            core_reg.regs.lock <= `RXAGC_RST_LOCK;
        end
        else
        begin
            core_reg <= core_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = core_reg.hrdata;
    assign vga_gain = core_reg.gain;
    assign second_front_amp_max = core_reg.regs.ctrl_two[`RXAGC_TWO_AMPMAX_BIT];
    assign second_front_amp_level = core_reg.regs.ctrl_two[`RXAGC_TWO_AMPLVL_BIT];
    assign carrier_sense = core_reg.cs;
    assign lock_pin = core_reg.lock_out;
    assign rssi_value = core_reg.avg;

endmodule : rxagc_top

`default_nettype wire

// >>> bench/rxagc_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// ****************
// Port checker
// ****************
module rxagc_chk (
    input wire logic clk_sys, // Clock
    input wire logic reset, // Reset
    input wire logic hsel, // Select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer
    input wire logic hwrite, // Write
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Ready
    input wire logic rx_enable, // Receiver on
    input wire logic [4:0] vga_gain, // Gain
    input wire logic second_front_amp_max, // Amp max
    input wire logic second_front_amp_level, // Amp level
    input wire logic carrier_sense, // Sense
    input wire logic lock_pin, // Lock pin
    input wire logic [7:0] rssi_value // RSSI
);
    logic a_wr;
    logic [2:0] a_idx;
    logic [7:0] sh [0:4];
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // Shadow of the control registers, taken in each write data phase
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            a_wr <= 1'b0;
            sh <= '{8'h00, 8'h55, 8'h2A, 8'h48, 8'h00};
        end
        else
        begin
            a_wr <= hsel && htrans[1] && hready && hwrite && haddr[7:0] < 8'h14;
            if (a_wr)
                sh[a_idx] <= hwdata[7:0];
        end
        a_idx <= haddr[4:2];
    end

    // Outputs against the shadowed settings
    a_gain_limit: assert property ($stable(sh[2]) |-> vga_gain <= sh[2][4:0])
        else $error("gain above maximum");
    a_gain_step: assert property (
        $changed(vga_gain) |-> vga_gain == sh[2][4:0] || vga_gain == $past(vga_gain) + 5'h01
        || vga_gain == $past(vga_gain) - 5'h01)
        else $error("gain moved more than one step");
    a_start_max: assert property ($rose(rx_enable) |-> ##[2:8] vga_gain == sh[2][4:0])
        else $error("activation did not start at maximum gain");
    a_idle_clear: assert property (!rx_enable [*6] |-> !carrier_sense)
        else $error("carrier sense set while receiver off");
    a_cs_gate: assert property ($rose(carrier_sense) |-> !$past(sh[4][4]))
        else $error("carrier sense set while gated");
    a_cs_level: assert property (
        $rose(carrier_sense) |-> {1'b0, rssi_value} > {4'h0, $past(sh[3][4:0])} + 9'h008)
        else $error("carrier sense below threshold");
    a_lock_mux: assert property (
        $stable(sh[4]) |-> lock_pin == (sh[4][3:0] == 4'h4 && $past(carrier_sense)))
        else $error("lock pin does not follow selection");
    a_amp_pins: assert property (
        second_front_amp_max == sh[1][5] && second_front_amp_level == sh[1][4])
        else $error("amplifier pins differ from setting");
endmodule : rxagc_chk

bind rxagc_top rxagc_chk u_chk (.clk_sys(clk_sys), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .rx_enable(rx_enable), .vga_gain(vga_gain), .second_front_amp_max(second_front_amp_max),
    .second_front_amp_level(second_front_amp_level), .carrier_sense(carrier_sense),
    .lock_pin(lock_pin), .rssi_value(rssi_value));

`default_nettype wire

// >>> bench/rxagc_fe_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************
// Front end model
// ****************
module rxagc_fe_model (
    input wire logic clk_sys, // Clock
    input wire logic reset, // Reset
    input wire logic slow, // Halve tick rates
    input wire logic [7:0] mag_level, // Signal level
    output logic adc_clk_in, // ADC clock
    output logic filter_clk_in, // Filter clock
    output logic [7:0] mag_sample // Magnitude
);
    logic [4:0] div = 5'h00;
    logic slow_q = 1'b0;
    // Divider; rate changes only at the wrap so no tick is clipped
    always_ff @(posedge clk_sys)
    begin
        div <= reset ? 5'h00 : div + 5'h01;
        if (reset || div == 5'h1F)
            slow_q <= slow;
    end
    // Samples hold only while the filter clock is high
    assign adc_clk_in = slow_q ? div[2] : div[1];
    assign filter_clk_in = slow_q ? div[4] : div[3];
    assign mag_sample = filter_clk_in ? mag_level : ~mag_level;
endmodule : rxagc_fe_model

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ****************
// Bench
// ****************
module tb_top;
    // Limits from reset settings, maximum and level unchanged
    localparam int g_max = 10;
    int g_lo = 10;
    int g_hi = 11;
    localparam int g_cs = 16;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic rx_enable = 1'b0;
    logic pll_lock = 1'b1;
    logic freq_set_b = 1'b0;
    logic slow = 1'b0;
    logic m_off = 1'b0;
    logic [7:0] mag_level = 8'h00;
    logic [31:0] d;
    logic [4:0] last_gain = 5'h00;
    wire hready, hreadyout, adc_clk_in, filter_clk_in, amp_max, amp_lvl, carrier_sense, lock_pin;
    wire [31:0] hrdata;
    wire [4:0] vga_gain;
    wire [7:0] mag_sample, rssi_value;
    int errors = 0;
    int checked = 0;
    int m_gain = 0;
    int exp_q [$];

    // Clock and the single slave's ready
    assign hready = hreadyout;
    always #5 clk_sys = ~clk_sys;

    rxagc_top u_dut (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .adc_clk_in(adc_clk_in),
        .filter_clk_in(filter_clk_in), .rx_enable(rx_enable), .pll_lock(pll_lock),
        .freq_set_b(freq_set_b), .mag_sample(mag_sample), .vga_gain(vga_gain),
        .second_front_amp_max(amp_max), .second_front_amp_level(amp_lvl),
        .carrier_sense(carrier_sense), .lock_pin(lock_pin), .rssi_value(rssi_value));
    rxagc_fe_model u_fe (.clk_sys(clk_sys), .reset(reset), .slow(slow),
        .mag_level(mag_level), .adc_clk_in(adc_clk_in), .filter_clk_in(filter_clk_in),
        .mag_sample(mag_sample));

    task automatic test_done();
        if (errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want)
        begin
            errors++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk

    // One bus phase, ended by ready under a bound
    task automatic step();
        int n;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (hready !== 1'b1 && n < 40);
        if (hready !== 1'b1)
        begin
            errors++;
            test_done();
        end
    endtask : step

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        step();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        step();
        d = hrdata;
    endtask : bus

    // Model of the loop: gain steps expected for a steady level
    function automatic int predict(input int mag);
        int n;
        n = 0;
        while (!m_off && ((mag > g_hi && m_gain > 0) || (mag < g_lo && m_gain < g_max)))
        begin
            m_gain += (mag > g_hi) ? -1 : 1;
            exp_q.push_back(m_gain);
            n++;
        end
        return n;
    endfunction : predict

    task automatic run(input int mag, input logic sl);
        int n;
        mag_level <= 8'(mag);
        slow <= sl;
        n = predict(mag);
        repeat ((n + 3) * (sl ? 640 : 320) + 300)
        begin
            @(posedge clk_sys);
            if (vga_gain !== last_gain)
            begin
                chk(32'(vga_gain), exp_q.size() > 0 ? exp_q.pop_front() : -1);
                last_gain = vga_gain;
            end
        end
        chk(32'(exp_q.size()), 0);
        chk(32'(rssi_value), mag);
        chk(32'(carrier_sense), 32'(mag > g_cs));
        chk(32'(lock_pin), 32'(mag > g_cs));
        bus(1'b0, 8'h14, 32'h0);
        chk({d[12:8], d[3]}, {m_gain[4:0], mag > g_cs});
    endtask : run

    // Main sequence
    initial
    begin
        logic [31:0] rst [8];
        logic [31:0] w;
        int mags [5];
        void'($urandom(75819));
        rst = '{32'h00, 32'h55, 32'h2A, 32'h48, 32'h00, 32'h04, 32'h00, 32'h00};
        mags = '{128 + $urandom_range(99), 10, 9, 16, 17};
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b0, 8'(i * 4), 32'h0);
            chk(d, rst[i]);
        end
        w = $urandom();
        bus(1'b1, 8'h10, w);
        bus(1'b1, 8'h1C, w);
        bus(1'b0, 8'h10, 32'h0);
        chk(d, {24'h00_0000, w[7:0]});
        bus(1'b0, 8'h1C, 32'h0);
        chk(d, 32'h0);
        bus(1'b1, 8'h10, 32'h04);
        rx_enable <= 1'b1;
        m_gain = g_max;
        exp_q.push_back(g_max);
        for (int i = 0; i < 5; i++)
            run(mags[i], i[0]);
        // Relock, then a set switch, each restarts at maximum
        for (int k = 0; k < 2; k++)
        begin
            pll_lock <= k[0];
            freq_set_b <= k[0];
            repeat (8) @(posedge clk_sys);
            pll_lock <= 1'b1;
            m_gain = g_max;
            exp_q.push_back(g_max);
            run(17, k[0]);
        end
        // Loop off, then on with each change level
        foreach (rst[i])
        begin
            w = (i == 0) ? 32'hBF : (i == 1) ? 32'h45 : 32'h55;
            if (i < 3)
            begin
                bus(1'b1, 8'h04, w);
                @(posedge clk_sys);
                chk({amp_max, amp_lvl}, w[5:4]);
                m_off = w[7];
                if (m_off && m_gain != g_max)
                    exp_q.push_back(g_max);
                m_gain = m_off ? g_max : m_gain;
                run(17, 1'b0);
            end
        end
        // Hysteresis on with the loop running: limits widen to 8 and 13
        bus(1'b1, 8'h04, 32'h5D);
        g_lo = 8;
        g_hi = 13;
        run(7, 1'b0);
        run(12, 1'b0);
        rx_enable <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk(32'(carrier_sense), 32'h0);
        test_done();
    end
endmodule : tb_top

`default_nettype wire
